// File: stil_map.svh
`ifndef STIL_MAP_SVH
`define STIL_MAP_SVH

// ****************************************************************
// Register widths and scan lengths
// ****************************************************************
`define STIL_IR_LEN        3
`define STIL_ID_LEN        32
`define STIL_BSR_LEN       75
`define STIL_SEQ_W         88

// ****************************************************************
// Instruction codes
// ****************************************************************
`define STIL_OP_RING_HIZ   3'h0
`define STIL_OP_IDENT      3'h1
`define STIL_OP_SAMPLE_HIZ 3'h2
`define STIL_OP_RSVD_A     3'h3
`define STIL_OP_SNAPSHOT   3'h4
`define STIL_OP_RSVD_B     3'h5
`define STIL_OP_RSVD_C     3'h6
`define STIL_OP_PASS       3'h7

// ****************************************************************
// Capture and reset values
// ****************************************************************
`define STIL_IR_CAPTURE    3'h1
// Identification word; value is arbitrary, bit 0 marks presence
`define STIL_ID_VALUE      32'h0a5c_3e4b
`define STIL_BYPASS_CAP    1'b0

// ****************************************************************
// Timing
// ****************************************************************
`define STIL_CLK_PERIOD_NS 10
`define STIL_TCK_MIN_NS    100
`define STIL_TCK_HALF      ((`STIL_TCK_MIN_NS / `STIL_CLK_PERIOD_NS) / 2)
`define STIL_RESET_TMS     5

`endif

// File: stil_pkg.sv
package stil_pkg;

  // ****************************************************************
  // Test access port controller states
  // ****************************************************************
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE,
    TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
    TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } stil_tap_e;

  // ****************************************************************
  // Controller command kinds
  // ****************************************************************
  typedef enum logic [1:0] {
    CMD_RESET,
    CMD_IR_SCAN,
    CMD_DR_SCAN
  } stil_cmd_e;

endpackage : stil_pkg

// File: stil_link_if.sv
`timescale 1ns/100ps

// ****************************************************************
// Four-wire test link; TDO is three-state at the pin
// ****************************************************************
interface stil_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  logic tdo_line;

  // Released line floats high through the pin pull-up
  assign tdo_line = tdo_oe ? tdo : 1'b1;

  modport device (
    input  tck,
    input  tms,
    input  tdi,
    output tdo,
    output tdo_oe
  );

  modport ctrl (
    output tck,
    output tms,
    output tdi,
    input  tdo_line
  );
endinterface : stil_link_if

// File: stil_tap_device.sv
`timescale 1ns/100ps
`include "stil_map.svh"

// ****************************************************************
// SRAM test access port: instruction decode and scan path
// ****************************************************************

// Contract
// - Code 000 captures ring, outputs high-Z
// - Code 001 loads and shifts identification word
// - Code 010 captures ring, forces outputs high-Z
// - Controller never loads codes 011, 101, 110
// - Code 100 snapshots pins at Capture-DR
// - Code 111 shifts through one-bit bypass
// - Update-DR under sample changes nothing
// - Shift-DR shifts captured boundary data out
// - Test clock at most 10 MHz
// - Toggling signals capture unreliably; stop memory clock
// - Reset leaves identification instruction loaded
// - Five TMS-high edges reset test logic
// - Capture-IR loads 01 into low bits
// - TDI enters MSB rising; TDO LSB falling
module stil_tap_device (
  input  wire logic                     CLOCK_IN,
  input  wire logic                     RST_IN,
  input  wire logic [`STIL_BSR_LEN-1:0] RING_IN,
  output logic                          MEM_HIZ_OUT,
  output logic [`STIL_IR_LEN-1:0]       INSTR_OUT,
  stil_link_if.device                   link
);

  // ****************************************************************
  // Crossings between the memory and test clock domains
  // ****************************************************************
  logic                     rst_meta_r;
  logic                     rst_tck_r;
  logic [`STIL_BSR_LEN-1:0] ring_meta_r;
  logic [`STIL_BSR_LEN-1:0] ring_r;
  logic                     rst_hold_r;
  logic                     ack_meta_r;
  logic                     ack_r;

  // Hold reset until the test domain echoes it; TCK may be stopped
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      rst_hold_r <= 1'b1;
    end else if (ack_r) begin
      rst_hold_r <= 1'b0;
    end
    ack_meta_r <= rst_tck_r;
    ack_r      <= ack_meta_r;
  end

  // Power-up reset follows the system reset into the test domain
  always_ff @(posedge link.tck) begin
    rst_meta_r <= rst_hold_r;
    rst_tck_r  <= rst_meta_r;
  end

  // Ring bits are asynchronous; a toggling bit may be caught either way
  always_ff @(posedge link.tck) begin
    ring_meta_r <= RING_IN;
    ring_r      <= ring_meta_r;
  end

  // ****************************************************************
  // Controller state machine
  // ****************************************************************
  stil_pkg::stil_tap_e state_r;
  stil_pkg::stil_tap_e state_nxt;

  // Standard sixteen-state walk steered by TMS
  always_comb begin
    case (state_r)
      stil_pkg::TAP_RESET:
        state_nxt = link.tms ? stil_pkg::TAP_RESET : stil_pkg::TAP_IDLE;
      stil_pkg::TAP_IDLE:
        state_nxt = link.tms ? stil_pkg::TAP_SEL_DR : stil_pkg::TAP_IDLE;
      stil_pkg::TAP_SEL_DR:
        state_nxt = link.tms ? stil_pkg::TAP_SEL_IR : stil_pkg::TAP_CAP_DR;
      stil_pkg::TAP_CAP_DR:
        state_nxt = link.tms ? stil_pkg::TAP_EXIT1_DR
                             : stil_pkg::TAP_SHIFT_DR;
      stil_pkg::TAP_SHIFT_DR:
        state_nxt = link.tms ? stil_pkg::TAP_EXIT1_DR
                             : stil_pkg::TAP_SHIFT_DR;
      stil_pkg::TAP_EXIT1_DR:
        state_nxt = link.tms ? stil_pkg::TAP_UPD_DR
                             : stil_pkg::TAP_PAUSE_DR;
      stil_pkg::TAP_PAUSE_DR:
        state_nxt = link.tms ? stil_pkg::TAP_EXIT2_DR
                             : stil_pkg::TAP_PAUSE_DR;
      stil_pkg::TAP_EXIT2_DR:
        state_nxt = link.tms ? stil_pkg::TAP_UPD_DR
                             : stil_pkg::TAP_SHIFT_DR;
      stil_pkg::TAP_UPD_DR:
        state_nxt = link.tms ? stil_pkg::TAP_SEL_DR : stil_pkg::TAP_IDLE;
      stil_pkg::TAP_SEL_IR:
        state_nxt = link.tms ? stil_pkg::TAP_RESET : stil_pkg::TAP_CAP_IR;
      stil_pkg::TAP_CAP_IR:
        state_nxt = link.tms ? stil_pkg::TAP_EXIT1_IR
                             : stil_pkg::TAP_SHIFT_IR;
      stil_pkg::TAP_SHIFT_IR:
        state_nxt = link.tms ? stil_pkg::TAP_EXIT1_IR
                             : stil_pkg::TAP_SHIFT_IR;
      stil_pkg::TAP_EXIT1_IR:
        state_nxt = link.tms ? stil_pkg::TAP_UPD_IR
                             : stil_pkg::TAP_PAUSE_IR;
      stil_pkg::TAP_PAUSE_IR:
        state_nxt = link.tms ? stil_pkg::TAP_EXIT2_IR
                             : stil_pkg::TAP_PAUSE_IR;
      stil_pkg::TAP_EXIT2_IR:
        state_nxt = link.tms ? stil_pkg::TAP_UPD_IR
                             : stil_pkg::TAP_SHIFT_IR;
      stil_pkg::TAP_UPD_IR:
        state_nxt = link.tms ? stil_pkg::TAP_SEL_DR : stil_pkg::TAP_IDLE;
      default:
        state_nxt = stil_pkg::TAP_RESET;
    endcase
  end

  // Any path with TMS high five edges in a row lands in reset
  always_ff @(posedge link.tck) begin
    if (rst_tck_r) begin
      state_r <= stil_pkg::TAP_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // State and instruction decode
  // ****************************************************************
  logic [`STIL_IR_LEN-1:0] ir_r;
  logic [`STIL_IR_LEN-1:0] ir_sh_r;
  wire in_reset  = (state_r == stil_pkg::TAP_RESET);
  wire cap_ir    = (state_r == stil_pkg::TAP_CAP_IR);
  wire shift_ir  = (state_r == stil_pkg::TAP_SHIFT_IR);
  wire upd_ir    = (state_r == stil_pkg::TAP_UPD_IR);
  wire cap_dr    = (state_r == stil_pkg::TAP_CAP_DR);
  wire shift_dr  = (state_r == stil_pkg::TAP_SHIFT_DR);
  wire op_ring   = (ir_r == `STIL_OP_RING_HIZ);
  wire op_samp_z = (ir_r == `STIL_OP_SAMPLE_HIZ);
  wire op_snap   = (ir_r == `STIL_OP_SNAPSHOT);
  wire sel_id    = (ir_r == `STIL_OP_IDENT);
  wire sel_bsr   = op_ring | op_samp_z | op_snap;
  // Reserved codes fall back to bypass so the chain stays one bit long
  wire sel_byp   = ~sel_id & ~sel_bsr;
  wire hiz_req   = op_ring | op_samp_z;

  // ****************************************************************
  // Instruction register
  // ****************************************************************
  // Shift stage: fixed capture pattern, then TDI into the MSB
  always_ff @(posedge link.tck) begin
    if (cap_ir) begin
      ir_sh_r <= `STIL_IR_CAPTURE;
    end else if (shift_ir) begin
      ir_sh_r <= {link.tdi, ir_sh_r[`STIL_IR_LEN-1:1]};
    end
  end

  // Active instruction only changes on Update-IR or reset
  always_ff @(posedge link.tck) begin
    if (rst_tck_r || in_reset) begin
      ir_r <= `STIL_OP_IDENT;
    end else if (upd_ir) begin
      ir_r <= ir_sh_r;
    end
  end

  // ****************************************************************
  // Data registers
  // ****************************************************************
  logic [`STIL_BSR_LEN-1:0] bsr_r;
  logic [`STIL_ID_LEN-1:0]  id_r;
  logic                     byp_r;

  // Boundary register: capture ring, shift toward TDO; no update stage
  // so Update-DR leaves every pin and register as it was
  always_ff @(posedge link.tck) begin
    if (cap_dr && sel_bsr) begin
      bsr_r <= ring_r;
    end else if (shift_dr && sel_bsr) begin
      bsr_r <= {link.tdi, bsr_r[`STIL_BSR_LEN-1:1]};
    end
  end

  // Identification word loads at Capture-DR, then shifts out
  always_ff @(posedge link.tck) begin
    if (cap_dr && sel_id) begin
      id_r <= `STIL_ID_VALUE;
    end else if (shift_dr && sel_id) begin
      id_r <= {link.tdi, id_r[`STIL_ID_LEN-1:1]};
    end
  end

  // Single-bit bypass stage, cleared on capture
  always_ff @(posedge link.tck) begin
    if (cap_dr && sel_byp) begin
      byp_r <= `STIL_BYPASS_CAP;
    end else if (shift_dr && sel_byp) begin
      byp_r <= link.tdi;
    end
  end

  // ****************************************************************
  // Serial output on the falling edge
  // ****************************************************************
  logic tdo_r;
  logic tdo_oe_r;
  wire  dr_lsb  = sel_bsr ? bsr_r[0] : (sel_id ? id_r[0] : byp_r);
  wire  tdo_bit = shift_ir ? ir_sh_r[0] : dr_lsb;

  // Falling edge gives the far end half a period of setup
  always_ff @(negedge link.tck) begin
    if (rst_tck_r) begin
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else begin
      tdo_r    <= tdo_bit;
      tdo_oe_r <= shift_ir | shift_dr;
    end
  end

  assign link.tdo    = tdo_r;
  assign link.tdo_oe = tdo_oe_r;

  // ****************************************************************
  // High-Z request back to the memory clock domain
  // ****************************************************************
  logic hiz_tck_r;
  logic hiz_meta_r;
  logic hiz_r;
  logic [`STIL_IR_LEN-1:0] instr_r;

  // Registered before crossing so no decode glitch escapes
  always_ff @(posedge link.tck) begin
    if (rst_tck_r) begin
      hiz_tck_r <= 1'b0;
    end else begin
      hiz_tck_r <= hiz_req;
    end
  end

  // Level crossing; memory outputs follow two CLOCK_IN edges later
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      hiz_meta_r <= 1'b0;
      hiz_r      <= 1'b0;
    end else begin
      hiz_meta_r <= hiz_tck_r;
      hiz_r      <= hiz_meta_r;
    end
  end

  // Instruction observed for debug, registered in the test domain
  always_ff @(posedge link.tck) begin
    instr_r <= ir_r;
  end

  assign MEM_HIZ_OUT = hiz_r;
  assign INSTR_OUT   = instr_r;

endmodule : stil_tap_device

// File: stil_tap_ctrl.sv
`timescale 1ns/100ps
`include "stil_map.svh"

// ****************************************************************
// External test controller: drives scans over the four-wire link
// ****************************************************************
module stil_tap_ctrl (
  input  wire logic                     CLOCK_IN,
  input  wire logic                     RST_IN,
  input  wire logic                     CMD_VALID_IN,
  output logic                          CMD_READY_OUT,
  input  wire stil_pkg::stil_cmd_e      CMD_KIND_IN,
  input  wire logic [6:0]               CMD_LEN_IN,
  input  wire logic [`STIL_BSR_LEN-1:0] CMD_DATA_IN,
  output logic                          RSP_VALID_OUT,
  output logic                          RSP_ERR_OUT,
  output logic [`STIL_BSR_LEN-1:0]      RSP_DATA_OUT,
  output logic                          MEM_CLK_STOP_OUT,
  stil_link_if.ctrl                     link
);

  localparam int SEQ_W = `STIL_SEQ_W;
  localparam int BSR_W = `STIL_BSR_LEN;

  // ****************************************************************
  // Test clock divider
  // ****************************************************************
  logic [3:0] div_r;
  logic       tck_r;
  wire        div_end  = (div_r == 4'(`STIL_TCK_HALF - 1));
  wire        rise_evt = div_end & ~tck_r;
  wire        fall_evt = div_end & tck_r;

  // Half period of five system cycles keeps TCK at 10 MHz
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      div_r <= 4'h0;
      tck_r <= 1'b0;
    end else begin
      div_r <= div_end ? 4'h0 : div_r + 4'h1;
      tck_r <= div_end ? ~tck_r : tck_r;
    end
  end

  // ****************************************************************
  // Sequence build on command accept
  // ****************************************************************
  wire [6:0] n_bits  = (CMD_KIND_IN == stil_pkg::CMD_IR_SCAN)
                       ? 7'(`STIL_IR_LEN) : CMD_LEN_IN;
  wire [6:0] pre_len = (CMD_KIND_IN == stil_pkg::CMD_IR_SCAN)
                       ? 7'h4 : 7'h3;
  wire [SEQ_W-1:0] pre_tms = (CMD_KIND_IN == stil_pkg::CMD_IR_SCAN)
                       ? SEQ_W'(3) : SEQ_W'(1);
  wire [6:0] last_ix = pre_len + n_bits - 7'h1;
  wire [SEQ_W-1:0] scan_tms = pre_tms | (SEQ_W'(1) << last_ix)
                              | (SEQ_W'(1) << (last_ix + 7'h1));
  wire [SEQ_W-1:0] scan_tdi = SEQ_W'(CMD_DATA_IN) << pre_len;
  wire [2:0] ir_code  = CMD_DATA_IN[2:0];
  // Codes the device leaves unimplemented are never sent
  wire       ir_rsvd  = (ir_code == `STIL_OP_RSVD_A)
                      | (ir_code == `STIL_OP_RSVD_B)
                      | (ir_code == `STIL_OP_RSVD_C);
  wire       is_reset = (CMD_KIND_IN == stil_pkg::CMD_RESET);
  wire       is_ir    = (CMD_KIND_IN == stil_pkg::CMD_IR_SCAN);
  wire       is_dr    = (CMD_KIND_IN == stil_pkg::CMD_DR_SCAN);
  wire       bad_len  = is_dr & ((CMD_LEN_IN == 7'h0)
                      | (CMD_LEN_IN > 7'(BSR_W)));
  wire       refuse   = (is_ir & ir_rsvd) | bad_len | ~(is_reset
                      | is_ir | is_dr);

  // ****************************************************************
  // Bit walker
  // ****************************************************************
  logic              busy_r;
  logic              drove_r;
  logic [6:0]        idx_r;
  logic [6:0]        len_r;
  logic [6:0]        win_lo_r;
  logic [6:0]        win_n_r;
  logic [SEQ_W-1:0]  tms_seq_r;
  logic [SEQ_W-1:0]  tdi_seq_r;
  logic              tms_r;
  logic              tdi_r;
  logic              tdo_meta_r;
  logic              tdo_s_r;
  logic [BSR_W-1:0]  rx_r;
  logic              rsp_v_r;
  logic              rsp_e_r;
  logic [BSR_W-1:0]  rsp_d_r;
  logic              stop_r;

  wire accept  = CMD_VALID_IN & ~busy_r;
  wire in_win  = (idx_r >= win_lo_r) & (idx_r < win_lo_r + win_n_r);
  wire last    = (idx_r + 7'h1 == len_r);
  wire [BSR_W-1:0] rx_nxt = in_win ? {tdo_s_r, rx_r[BSR_W-1:1]} : rx_r;
  wire [6:0]       rx_sh  = 7'(BSR_W) - win_n_r;

  // Device output is on another clock; two flops before use
  always_ff @(posedge CLOCK_IN) begin
    tdo_meta_r <= link.tdo_line;
    tdo_s_r    <= tdo_meta_r;
  end

  // Load on accept; reset is five TMS-high edges then one low
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      busy_r <= 1'b0;
      stop_r <= 1'b0;
    end else if (accept && !refuse) begin
      busy_r    <= 1'b1;
      stop_r    <= is_dr;
      idx_r     <= 7'h0;
      len_r     <= is_reset ? 7'(`STIL_RESET_TMS + 1) : last_ix + 7'h3;
      win_lo_r  <= pre_len;
      win_n_r   <= is_reset ? 7'h0 : n_bits;
      tms_seq_r <= is_reset ? SEQ_W'(32'h1f) : scan_tms;
      tdi_seq_r <= is_reset ? '0 : scan_tdi;
    end else if (busy_r && rise_evt && drove_r) begin
      idx_r  <= idx_r + 7'h1;
      busy_r <= ~last;
      stop_r <= stop_r & ~last;
    end
  end

  // Pins change on TCK falling, device samples on the next rise
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      tms_r   <= 1'b1;
      tdi_r   <= 1'b1;
      drove_r <= 1'b0;
    end else if (fall_evt) begin
      tms_r   <= busy_r ? tms_seq_r[idx_r] : 1'b0;
      tdi_r   <= busy_r ? tdi_seq_r[idx_r] : 1'b1;
      drove_r <= busy_r;
    end else if (rise_evt) begin
      drove_r <= 1'b0;
    end
  end

  // Collect shifted-out bits LSB first, right-justify at the end
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      rsp_v_r <= 1'b0;
      rsp_e_r <= 1'b0;
      rsp_d_r <= '0;
    end else if (accept && refuse) begin
      rsp_v_r <= 1'b1;
      rsp_e_r <= 1'b1;
      rsp_d_r <= '0;
    end else if (busy_r && rise_evt && drove_r && last) begin
      rsp_v_r <= 1'b1;
      rsp_e_r <= 1'b0;
      rsp_d_r <= rx_nxt >> rx_sh;
    end else begin
      rsp_v_r <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN || accept) begin
      rx_r <= '0;
    end else if (busy_r && rise_evt && drove_r) begin
      rx_r <= rx_nxt;
    end
  end

  assign link.tck         = tck_r;
  assign link.tms         = tms_r;
  assign link.tdi         = tdi_r;
  assign CMD_READY_OUT    = ~busy_r;
  assign RSP_VALID_OUT    = rsp_v_r;
  assign RSP_ERR_OUT      = rsp_e_r;
  assign RSP_DATA_OUT     = rsp_d_r;
  assign MEM_CLK_STOP_OUT = stop_r;

endmodule : stil_tap_ctrl

// File: stil_link_properties.sv
`timescale 1ns/100ps
`include "stil_map.svh"

// ****************************************************************
// Link checker: tracks the controller state from tms, watches wire
// ****************************************************************
module stil_link_properties (
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // Next-state tables, one nibble per state, for tms low and tms high
  localparam logic [63:0] NXT0    = 64'h1bddbba1_46644311;
  localparam logic [63:0] NXT1    = 64'h2fefcc02_87855920;
  localparam logic [31:0] ID_WORD = `STIL_ID_VALUE;

  logic [3:0] st_r;
  logic [3:0] st_nxt;
  logic [3:0] hi_r = 4'h0;
  logic       ok_r = 1'b0;
  logic [2:0] ir_sh_r;
  logic [2:0] ir_r;
  logic [6:0] idx_r;
  logic [3:0] per_r;
  logic [3:0] half_r;
  logic       reset_seen;
  logic       shift_dr;
  logic       shifting;

  // Model trusted only once five tms-high edges forced a known state
  assign st_nxt     = tms ? NXT1[{st_r, 2'b00} +: 4] : NXT0[{st_r, 2'b00} +: 4];
  assign reset_seen = tms && (hi_r >= 4'h4);
  assign shift_dr   = (st_r == stil_pkg::TAP_SHIFT_DR);
  assign shifting   = shift_dr || (st_r == stil_pkg::TAP_SHIFT_IR);

  // Controller state and consecutive tms-high count
  always_ff @(posedge tck) begin
    hi_r <= !tms ? 4'h0 : ((hi_r == 4'h5) ? hi_r : hi_r + 4'h1);
    st_r <= reset_seen ? 4'h0 : st_nxt;
    ok_r <= ok_r | reset_seen;
  end

  // Instruction shadow and scan bit index
  always_ff @(posedge tck) begin
    ir_sh_r <= (st_r == stil_pkg::TAP_SHIFT_IR) ? {tdi, ir_sh_r[2:1]} : ir_sh_r;
    ir_r    <= (st_r == stil_pkg::TAP_RESET) ? `STIL_OP_IDENT :
               (st_r == stil_pkg::TAP_UPD_IR) ? ir_sh_r : ir_r;
    idx_r   <= !shift_dr ? 7'h00 : ((idx_r == 7'h7f) ? idx_r : idx_r + 7'h01);
  end

  // Test clock spacing in memory clock cycles; saturates after reset
  always_ff @(posedge CLOCK_IN) begin
    per_r  <= RST_IN ? 4'hf : ($rose(tck) ? 4'h0 :
              ((per_r == 4'hf) ? per_r : per_r + 4'h1));
    half_r <= RST_IN ? 4'hf : ($changed(tck) ? 4'h0 :
              ((half_r == 4'hf) ? half_r : half_r + 4'h1));
  end

  sequence s_cap_ir;
    ok_r && (st_r == stil_pkg::TAP_CAP_IR);
  endsequence

  sequence s_low_bits;
    tdo ##1 !tdo;
  endsequence

  a_tdo_enable_shift: assert property (@(posedge tck) disable iff (RST_IN)
    ok_r |-> (tdo_oe == shifting)) else $error("tdo enable outside shift");
  a_ir_capture_bits: assert property (@(posedge tck) disable iff (RST_IN)
    s_cap_ir |=> s_low_bits) else $error("capture pattern wrong");
  a_id_word_out: assert property (@(posedge tck) disable iff (RST_IN)
    ok_r && shift_dr && (ir_r == `STIL_OP_IDENT) && (idx_r < 7'h20)
    |-> (tdo == ID_WORD[idx_r[4:0]])) else $error("ident bit wrong");
  a_bypass_first_zero: assert property (@(posedge tck) disable iff (RST_IN)
    ok_r && shift_dr && (ir_r == `STIL_OP_PASS) && (idx_r == 7'h00)
    |-> (tdo == `STIL_BYPASS_CAP)) else $error("bypass capture wrong");
  a_bypass_one_bit: assert property (@(posedge tck) disable iff (RST_IN)
    ok_r && shift_dr && (ir_r == `STIL_OP_PASS) && (idx_r != 7'h00)
    |-> (tdo == $past(tdi))) else $error("bypass delay wrong");
  a_output_falling_edge: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    ($changed(tdo) || $changed(tdo_oe)) |-> $fell(tck))
    else $error("tdo moved off falling edge");
  a_tck_period_min: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    $rose(tck) |-> (per_r >= 4'h9)) else $error("test clock too fast");
  a_tck_half_min: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    $changed(tck) |-> (half_r >= 4'h3)) else $error("test clock phase short");
endmodule : stil_link_properties

// File: tb.sv
`timescale 1ns/100ps
`include "stil_map.svh"

module tb;
  logic                clk       = 1'b0;
  logic                rst       = 1'b1;
  logic                cmd_valid = 1'b0;
  stil_pkg::stil_cmd_e cmd_kind  = stil_pkg::CMD_RESET;
  logic [6:0]          cmd_len   = 7'h00;
  logic [74:0]         cmd_data  = 75'h0;
  logic [74:0]         ring      = 75'h4a5_1234_5678_9abc_def0;
  logic                cmd_ready;
  logic                rsp_valid;
  logic                rsp_err;
  logic [74:0]         rsp_data;
  logic                clk_stop;
  logic                mem_hiz;
  logic [2:0]          instr;
  logic [74:0]         got_data;
  logic                got_err;
  logic                stop_seen;
  int                  miscompares = 0;
  int                  comparisons = 0;

  // Memory clock, 100 MHz; the test clock comes from the controller
  always #5 clk = ~clk;

  stil_link_if stil_link_if_inst ();

  stil_tap_device stil_tap_device_inst (.CLOCK_IN(clk), .RST_IN(rst),
    .RING_IN(ring), .MEM_HIZ_OUT(mem_hiz), .INSTR_OUT(instr),
    .link(stil_link_if_inst));

  stil_tap_ctrl stil_tap_ctrl_inst (.CLOCK_IN(clk), .RST_IN(rst),
    .CMD_VALID_IN(cmd_valid), .CMD_READY_OUT(cmd_ready),
    .CMD_KIND_IN(cmd_kind), .CMD_LEN_IN(cmd_len), .CMD_DATA_IN(cmd_data),
    .RSP_VALID_OUT(rsp_valid), .RSP_ERR_OUT(rsp_err),
    .RSP_DATA_OUT(rsp_data), .MEM_CLK_STOP_OUT(clk_stop),
    .link(stil_link_if_inst));

  stil_link_properties stil_link_properties_inst (.CLOCK_IN(clk),
    .RST_IN(rst), .tck(stil_link_if_inst.tck),
    .tms(stil_link_if_inst.tms), .tdi(stil_link_if_inst.tdi),
    .tdo(stil_link_if_inst.tdo), .tdo_oe(stil_link_if_inst.tdo_oe));

  // ****************************************************************
  // Reporting and comparison
  // ****************************************************************
  task tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  task check_bit(input logic got, input logic exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      $display("unexpected at %0t: %s", $time, msg);
      miscompares++;
    end
  endtask : check_bit

  task check_word(input logic [74:0] got, input logic [74:0] exp,
                  input string msg);
    comparisons++;
    if (got !== exp) begin
      $display("unexpected at %0t: %s", $time, msg);
      miscompares++;
    end
  endtask : check_word

  // One command: hold valid until taken, then wait for the pulse
  task run_cmd(input stil_pkg::stil_cmd_e k, input logic [6:0] n,
               input logic [74:0] d);
    int   i;
    logic done;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_kind  <= k;
    cmd_len   <= n;
    cmd_data  <= d;
    done      = 1'b0;
    for (i = 0; i < 100 && !done; i++) begin
      #1 done = (cmd_ready === 1'b1);
      @(posedge clk);
    end
    cmd_valid <= 1'b0;
    stop_seen = 1'b0;
    for (i = 0; i < 3000 && done; i++) begin
      #1 stop_seen = stop_seen | (clk_stop === 1'b1);
      if (rsp_valid === 1'b1) begin
        got_data = rsp_data;
        got_err  = rsp_err;
        break;
      end
      @(posedge clk);
    end
    if (!done || i == 3000) begin
      $display("unexpected at %0t: command not answered", $time);
      miscompares++;
      tally_and_finish();
    end
  endtask : run_cmd

  // Instruction load, then time for the high-Z flag to cross over
  task ir_scan(input logic [2:0] code);
    run_cmd(stil_pkg::CMD_IR_SCAN, 7'h03, {72'h0, code});
    repeat (16) @(posedge clk);
  endtask : ir_scan

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task test_reset_ident;
    run_cmd(stil_pkg::CMD_RESET, 7'h00, 75'h0);
    run_cmd(stil_pkg::CMD_DR_SCAN, 7'h20, 75'h0);
    check_word({43'h0, got_data[31:0]}, {43'h0, `STIL_ID_VALUE}, "ident");
    check_bit(stop_seen, 1'b1, "memory clock not stopped");
    check_bit(mem_hiz, 1'b0, "ident disturbs memory");
    $display("test_reset_ident done");
  endtask : test_reset_ident

  task test_bypass;
    ir_scan(`STIL_OP_PASS);
    check_word({73'h0, got_data[1:0]}, 75'h1, "capture pattern");
    check_word({72'h0, instr}, {72'h0, `STIL_OP_PASS}, "instr");
    run_cmd(stil_pkg::CMD_DR_SCAN, 7'h08, 75'ha5);
    check_word({67'h0, got_data[7:0]}, 75'h4a, "bypass path");
    check_bit(mem_hiz, 1'b0, "bypass disturbs memory");
    $display("test_bypass done");
  endtask : test_bypass

  // Capturing codes in a table, each with its expected high-Z flag
  task test_boundary;
    logic [2:0] codes [3];
    logic       hiz   [3];
    int         i;
    codes = '{`STIL_OP_RING_HIZ, `STIL_OP_SAMPLE_HIZ, `STIL_OP_SNAPSHOT};
    hiz   = '{1'b1, 1'b1, 1'b0};
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      ring <= ring ^ {72'h0, codes[i]} ^ {i[2:0], 72'h0};
      ir_scan(codes[i]);
      check_bit(got_err, 1'b0, "capture code refused");
      check_bit(mem_hiz, hiz[i], "high-Z flag");
      run_cmd(stil_pkg::CMD_DR_SCAN, 7'h4b, ~ring);
      check_word(got_data, ring, "boundary capture");
    end
    run_cmd(stil_pkg::CMD_DR_SCAN, 7'h4b, 75'h0);
    check_word(got_data, ring, "update changed ring");
    check_bit(mem_hiz, 1'b0, "update changed pins");
    $display("test_boundary done");
  endtask : test_boundary

  task test_reserved;
    logic [2:0] codes [3];
    int         i;
    codes = '{`STIL_OP_RSVD_A, `STIL_OP_RSVD_B, `STIL_OP_RSVD_C};
    for (i = 0; i < 3; i++) begin
      ir_scan(codes[i]);
      check_bit(got_err, 1'b1, "reserved code sent");
    end
    run_cmd(stil_pkg::CMD_RESET, 7'h00, 75'h0);
    run_cmd(stil_pkg::CMD_DR_SCAN, 7'h20, 75'h0);
    check_word({43'h0, got_data[31:0]}, {43'h0, `STIL_ID_VALUE}, "reident");
    $display("test_reserved done");
  endtask : test_reserved

  // Reset held for eight cycles, then the scenarios in turn
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    test_reset_ident();
    test_bypass();
    test_boundary();
    test_reserved();
    tally_and_finish();
  end
endmodule : tb
